// File: dsr_pkg.sv
// Package for the disk controller status and error register bank.
// Assumes a 32-bit classic Wishbone host and an 8-bit register layout.
package dsr_pkg;

    localparam int unsigned DSR_BUS_DW = 32;
    localparam int unsigned DSR_ADR_W  = 8;
    localparam int unsigned DSR_REG_W  = 8;

    // Byte addresses of the register words.
    localparam logic [7:0] DSR_OFF_STATUS = 8'h00;
    localparam logic [7:0] DSR_OFF_ERROR  = 8'h04;
    localparam logic [7:0] DSR_OFF_IRQ_ST = 8'h08;
    localparam logic [7:0] DSR_OFF_IRQ_MK = 8'h0c;
    localparam logic [7:0] DSR_OFF_CTRL   = 8'h10;

    // Field positions of the controller status register.
    localparam int unsigned DSR_ST_BUSY  = 7;
    localparam int unsigned DSR_ST_READY = 6;
    localparam int unsigned DSR_ST_WFLT  = 5;
    localparam int unsigned DSR_ST_SEEK  = 4;
    localparam int unsigned DSR_ST_XFER  = 3;
    localparam int unsigned DSR_ST_FIXED = 2;
    localparam int unsigned DSR_ST_INDEX = 1;
    localparam int unsigned DSR_ST_ERR   = 0;

    // Field positions of the command error cause register.
    localparam int unsigned DSR_ER_BADBLK = 7;
    localparam int unsigned DSR_ER_UNCORR = 6;
    localparam int unsigned DSR_ER_IDMISS = 4;
    localparam int unsigned DSR_ER_ABORT  = 2;
    localparam int unsigned DSR_ER_TRK0   = 1;
    localparam logic [7:0]  DSR_ER_UNUSED = 8'h29;

    // Field positions of the interrupt status and mask registers.
    localparam int unsigned DSR_IRQ_DONE = 0;
    localparam int unsigned DSR_IRQ_FAIL = 1;
    localparam int unsigned DSR_IRQ_XFER = 2;
    localparam int unsigned DSR_IRQ_N    = 3;

    // Control register: bit 0 written as one launches a command.
    localparam int unsigned DSR_CTRL_GO = 0;

    // Reset values.
    localparam logic [7:0] DSR_RST_STATUS = 8'h00;
    localparam logic [7:0] DSR_RST_ERROR  = 8'h00;
    localparam logic [2:0] DSR_RST_IRQ    = 3'h0;

    // Levels reported by the drive mechanics.
    typedef struct packed {
        logic drive_ready_flag;
        logic write_fault_flag;
        logic seek_settled_flag;
        logic transfer_request_flag;
        logic index_mark_flag;
    } dsr_drive_t;

    // Causes reported with the end of a command.
    typedef struct packed {
        logic bad_block_flag;
        logic uncorrectable_flag;
        logic sector_id_missing_flag;
        logic command_aborted_flag;
        logic track0_missing_flag;
    } dsr_cause_t;

endpackage

// File: dsr_sticky.sv
// Bank of sticky flags with per-bit set and clear; set wins over clear.
// Assumes set and clear are synchronous single-cycle or level requests.
`timescale 1ns/100ps
module dsr_sticky
    import dsr_pkg::*;
#(
    parameter int unsigned         W   = 1,
    parameter logic [W-1:0]        RST = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic      [W-1:0] flag
);

    logic [W-1:0] flag_reg;

    // A new event in the clearing cycle must not be lost.
    always_ff @(posedge clk) begin
        if (rst) begin
            flag_reg <= RST;
        end else begin
            flag_reg <= set | (flag_reg & ~clr);
        end
    end

    assign flag = flag_reg;

endmodule

// File: dsr_regs.sv
// Status and error register bank of a disk controller, Wishbone slave.
// Assumes the drive engine gives synchronous levels and one-cycle done pulses.
`timescale 1ns/100ps
// Contract
// - Bit 6 shows drive ready for commands.
// - Bit 5 shows drive write fault.
// - Bit 4 shows heads settled after seek.
// - Bit 3 shows drive ready for data.
// - Bit 2 shows corrected read error.
// - Bit 0 shows last command ended erroneously.
// - Error bit 7 flags bad block mark.
// - Error bit 6 flags uncorrectable data.
// - Error bit 4 flags missing sector ID.
// - Error bit 2 flags aborted command.
// - Error bit 1 flags track 0 missing.
module dsr_regs
    import dsr_pkg::*;
#(
    parameter int unsigned DW = DSR_BUS_DW
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [DSR_ADR_W-1:0] wb_adr_i,
    input  wire logic [DW/8-1:0]      wb_sel_i,
    input  wire logic [DW-1:0]        wb_dat_i,
    output logic      [DW-1:0]        wb_dat_o,
    output logic                      wb_ack_o,
    input  wire dsr_drive_t           drive_i,
    input  wire logic                 corrected_i,
    input  wire logic                 cmd_done_i,
    input  wire dsr_cause_t           cause_i,
    output logic                      cmd_start_o,
    output logic      [DSR_REG_W-1:0] controller_status_o,
    output logic                      irq_o
);

    if (DW != DSR_BUS_DW) begin : g_bad_dw
        $error("dsr_regs supports only a 32-bit data bus");
    end

    logic [DSR_REG_W-1:0] controller_status_reg;
    logic [DSR_REG_W-1:0] controller_status_next;
    logic [DSR_REG_W-1:0] command_error_cause_reg;
    logic [DSR_REG_W-1:0] command_error_cause_next;
    logic                 busy_reg;
    logic                 error_flag_reg;
    logic                 ack_reg;
    logic [DW-1:0]        dat_reg;
    logic [DW-1:0]        dat_next;
    logic                 start_reg;
    logic                 irq_reg;
    logic [DSR_IRQ_N-1:0] irq_mask_reg;
    logic [DSR_IRQ_N-1:0] irq_status;
    logic [DSR_IRQ_N-1:0] irq_set;
    logic [DSR_IRQ_N-1:0] irq_clr;
    logic                 fixed_flag;
    logic                 xfer_prev_reg;
    logic                 cause_any;
    logic                 req;
    logic                 wr_lane0;
    logic                 go_write;

    // A request is served once; writes land at the edge where the master sees ack.
    assign req      = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr_lane0 = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];
    assign go_write = wr_lane0 & (wb_adr_i == DSR_OFF_CTRL) & wb_dat_i[DSR_CTRL_GO];

    assign cause_any = cause_i.bad_block_flag | cause_i.uncorrectable_flag
                     | cause_i.sector_id_missing_flag | cause_i.command_aborted_flag
                     | cause_i.track0_missing_flag;

    // Bus handshake: one wait state, then a one-cycle ack.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req;
        end
    end

    always_comb begin
        dat_next = '0;
        unique case (wb_adr_i)
            DSR_OFF_STATUS: dat_next[DSR_REG_W-1:0] = controller_status_reg;
            DSR_OFF_ERROR:  dat_next[DSR_REG_W-1:0] = command_error_cause_reg;
            DSR_OFF_IRQ_ST: dat_next[DSR_IRQ_N-1:0] = irq_status;
            DSR_OFF_IRQ_MK: dat_next[DSR_IRQ_N-1:0] = irq_mask_reg;
            DSR_OFF_CTRL:   dat_next[DSR_CTRL_GO]   = busy_reg;
            default:        dat_next = '0;
        endcase
    end

    // Unmapped addresses are acknowledged and read as zero.
    always_ff @(posedge clk) begin
        if (rst) begin
            dat_reg <= '0;
        end else if (req && !wb_we_i) begin
            dat_reg <= dat_next;
        end
    end

    // Command life cycle: a control write launches, the engine ends it.
    always_ff @(posedge clk) begin
        if (rst) begin
            busy_reg  <= 1'b0;
            start_reg <= 1'b0;
        end else begin
            start_reg <= go_write & ~busy_reg;
            if (cmd_done_i) begin
                busy_reg <= 1'b0;
            end else if (go_write) begin
                busy_reg <= 1'b1;
            end
        end
    end

    // Error flag and causes are loaded at command end; a launch clears them,
    // but an end in the same cycle wins so its report is never lost.
    always_comb begin
        command_error_cause_next = command_error_cause_reg;
        if (cmd_done_i) begin
            command_error_cause_next = '0;
            command_error_cause_next[DSR_ER_BADBLK] = cause_i.bad_block_flag;
            command_error_cause_next[DSR_ER_UNCORR] = cause_i.uncorrectable_flag;
            command_error_cause_next[DSR_ER_IDMISS] = cause_i.sector_id_missing_flag;
            command_error_cause_next[DSR_ER_ABORT]  = cause_i.command_aborted_flag;
            command_error_cause_next[DSR_ER_TRK0]   = cause_i.track0_missing_flag;
        end else if (go_write && !busy_reg) begin
            command_error_cause_next = '0;
        end
        command_error_cause_next = command_error_cause_next & ~DSR_ER_UNUSED;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            command_error_cause_reg <= DSR_RST_ERROR;
            error_flag_reg          <= 1'b0;
        end else begin
            command_error_cause_reg <= command_error_cause_next;
            if (cmd_done_i) begin
                error_flag_reg <= cause_any;
            end else if (go_write && !busy_reg) begin
                error_flag_reg <= 1'b0;
            end
        end
    end

    // Corrected-read indication holds until the next command launch.
    dsr_sticky #(
        .W   (1),
        .RST (1'b0)
    ) u_fixed (
        .clk  (clk),
        .rst  (rst),
        .set  (corrected_i),
        .clr  (start_reg),
        .flag (fixed_flag)
    );

    // Busy is shown inverted: zero while busy, one while ready.
    always_comb begin
        controller_status_next               = DSR_RST_STATUS;
        controller_status_next[DSR_ST_BUSY]  = ~busy_reg;
        controller_status_next[DSR_ST_READY] = drive_i.drive_ready_flag;
        controller_status_next[DSR_ST_WFLT]  = drive_i.write_fault_flag;
        controller_status_next[DSR_ST_SEEK]  = drive_i.seek_settled_flag;
        controller_status_next[DSR_ST_XFER]  = drive_i.transfer_request_flag;
        controller_status_next[DSR_ST_FIXED] = fixed_flag;
        controller_status_next[DSR_ST_INDEX] = drive_i.index_mark_flag;
        controller_status_next[DSR_ST_ERR]   = error_flag_reg;
    end

    // Status is sampled every cycle, so it lags its sources by one clock.
    always_ff @(posedge clk) begin
        if (rst) begin
            controller_status_reg <= DSR_RST_STATUS;
        end else begin
            controller_status_reg <= controller_status_next;
        end
    end

    // Interrupt events: command done, command failed, transfer request rise.
    always_ff @(posedge clk) begin
        if (rst) begin
            xfer_prev_reg <= 1'b0;
        end else begin
            xfer_prev_reg <= drive_i.transfer_request_flag;
        end
    end

    always_comb begin
        irq_set               = '0;
        irq_set[DSR_IRQ_DONE] = cmd_done_i;
        irq_set[DSR_IRQ_FAIL] = cmd_done_i & cause_any;
        irq_set[DSR_IRQ_XFER] = drive_i.transfer_request_flag & ~xfer_prev_reg;
        irq_clr               = '0;
        if (wr_lane0 && wb_adr_i == DSR_OFF_IRQ_ST) begin
            irq_clr = wb_dat_i[DSR_IRQ_N-1:0];
        end
    end

    dsr_sticky #(
        .W   (DSR_IRQ_N),
        .RST (DSR_RST_IRQ)
    ) u_irq (
        .clk  (clk),
        .rst  (rst),
        .set  (irq_set),
        .clr  (irq_clr),
        .flag (irq_status)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_mask_reg <= DSR_RST_IRQ;
        end else if (wr_lane0 && wb_adr_i == DSR_OFF_IRQ_MK) begin
            irq_mask_reg <= wb_dat_i[DSR_IRQ_N-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(irq_status & irq_mask_reg);
        end
    end

    assign wb_ack_o            = ack_reg;
    assign wb_dat_o            = dat_reg;
    assign cmd_start_o         = start_reg;
    assign controller_status_o = controller_status_reg;
    assign irq_o               = irq_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_launch;
        go_write && !busy_reg && !cmd_done_i;
    endsequence

    sequence s_idle_status;
        controller_status_o[DSR_ST_BUSY] ##0 !controller_status_o[DSR_ST_ERR];
    endsequence

    AST_BUSY_SHOWN: assert property (s_launch |-> ##2 !controller_status_o[DSR_ST_BUSY])
        else $error("busy bit not low two cycles after launch");

    AST_READY_SHOWN: assert property (cmd_done_i |-> ##2 controller_status_o[DSR_ST_BUSY])
        else $error("busy bit not high two cycles after command end");

    AST_READY_BIT: assert property (
        ##1 controller_status_o[DSR_ST_READY] == $past(drive_i.drive_ready_flag))
        else $error("drive ready bit does not follow drive");

    AST_WFLT: assert property (
        drive_i.write_fault_flag |=> controller_status_o[DSR_ST_WFLT])
        else $error("write fault bit missed");

    AST_SEEK: assert property (
        !drive_i.seek_settled_flag |=> !controller_status_o[DSR_ST_SEEK])
        else $error("seek settled bit set while unsettled");

    AST_XFER: assert property (
        $rose(drive_i.transfer_request_flag)
        |=> controller_status_o[DSR_ST_XFER] ##0 irq_status[DSR_IRQ_XFER])
        else $error("transfer request not shown");

    AST_FIXED: assert property (
        corrected_i && !start_reg |-> ##2 controller_status_o[DSR_ST_FIXED])
        else $error("corrected bit not set");

    AST_INDEX: assert property (
        drive_i.index_mark_flag |=> controller_status_o[DSR_ST_INDEX])
        else $error("index bit not shown");

    AST_ERR_FLAG: assert property (cmd_done_i && !cause_any |-> ##2 s_idle_status)
        else $error("error bit set after clean command end");

    AST_BADBLK: assert property (
        cmd_done_i && cause_i.bad_block_flag
        |=> command_error_cause_reg[DSR_ER_BADBLK] && error_flag_reg)
        else $error("bad block cause lost");

    AST_UNCORR: assert property (
        cmd_done_i
        |=> command_error_cause_reg[DSR_ER_UNCORR] == $past(cause_i.uncorrectable_flag))
        else $error("uncorrectable cause wrong");

    AST_IDMISS: assert property (
        cmd_done_i
        |=> command_error_cause_reg[DSR_ER_IDMISS] == $past(cause_i.sector_id_missing_flag))
        else $error("sector id cause wrong");

    AST_ABORT: assert property (
        cmd_done_i && cause_i.command_aborted_flag |=> ##1 controller_status_o[DSR_ST_ERR])
        else $error("abort did not raise error bit");

    AST_TRK0: assert property (
        cmd_done_i && !cause_i.track0_missing_flag |=> !command_error_cause_reg[DSR_ER_TRK0])
        else $error("track 0 cause not cleared");

    AST_UNUSED: assert property ((command_error_cause_reg & DSR_ER_UNUSED) == 8'h00)
        else $error("unused error bits not zero");

    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    AST_ACK_TIMING: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");

    AST_RD_UPPER: assert property (wb_ack_o |-> wb_dat_o[DW-1:DSR_REG_W] == '0)
        else $error("upper read data bits not zero");

    AST_NO_RELAUNCH: assert property (go_write && busy_reg |=> !cmd_start_o)
        else $error("launch accepted while busy");

    AST_START_ONE: assert property (cmd_start_o |=> !cmd_start_o)
        else $error("launch pulse longer than one cycle");

    AST_BUSY_LEVEL: assert property (busy_reg |=> !controller_status_o[DSR_ST_BUSY])
        else $error("busy bit reads ready while busy");

    AST_ERR_CLEAR: assert property (s_launch |=> command_error_cause_reg == 8'h00)
        else $error("error causes not cleared at launch");

    AST_ERR_HOLD: assert property (!cmd_done_i && !go_write |=> $stable(command_error_cause_reg))
        else $error("error causes changed between commands");

    AST_IRQ_ON: assert property ((irq_status & irq_mask_reg) != 3'h0 |=> irq_o)
        else $error("interrupt not raised");

    AST_IRQ_OFF: assert property ((irq_status & irq_mask_reg) == 3'h0 |=> !irq_o)
        else $error("interrupt raised without cause");

    AST_IRQ_DONE: assert property (cmd_done_i |=> irq_status[DSR_IRQ_DONE])
        else $error("command done event lost");

    AST_IRQ_FAIL: assert property (cmd_done_i && cause_any |=> irq_status[DSR_IRQ_FAIL])
        else $error("command failure event lost");

    AST_FIXED_CLEAR: assert property (
        cmd_start_o && !corrected_i |=> ##1 !controller_status_o[DSR_ST_FIXED])
        else $error("corrected bit survived a launch");

    AST_XFER_LOW: assert property (
        !drive_i.transfer_request_flag |=> !controller_status_o[DSR_ST_XFER])
        else $error("transfer bit set without request");

endmodule

// File: dsr_drive_model.sv
// Behavioural drive engine standing behind the register bank.
// Assumes the bank pulses its launch output for one cycle per command.
`timescale 1ns/100ps
module dsr_drive_model
    import dsr_pkg::*;
#(
    parameter int unsigned DLY = 12
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       start,
    input  wire dsr_cause_t cause_cfg,
    output logic            done,
    output dsr_cause_t      cause
);
    int cnt;

    // The cause is only valid with done; elsewhere it shows junk, as a real engine may.
    assign cause = done ? cause_cfg : ~cause_cfg;

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt  <= 0;
            done <= 1'b0;
        end else begin
            done <= (cnt == 1);
            if (start) begin
                cnt <= DLY;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule

// File: tb.sv
// Self-checking bench for the status and error register bank.
// Assumes a classic Wishbone host and the drive engine model beside it.
`timescale 1ns/100ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb
    import dsr_pkg::*;
;
    logic        clk, rst, cyc, stb, we, fix, done, ack, start, irq;
    logic [7:0]  adr, st_o;
    logic [3:0]  sel;
    logic [31:0] wd, rdat, rd;
    dsr_drive_t  drv;
    dsr_cause_t  ccfg, cause;
    int          num_errors, cmp_count, cycles, starts;
    logic [7:0]  dpos [5] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02};
    logic [7:0]  cpos [5] = '{8'h80, 8'h40, 8'h10, 8'h04, 8'h02};

    dsr_regs i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack),
        .drive_i(drv), .corrected_i(fix), .cmd_done_i(done), .cause_i(cause),
        .cmd_start_o(start), .controller_status_o(st_o), .irq_o(irq));

    dsr_drive_model i_drive (.clk(clk), .rst(rst), .start(start), .cause_cfg(ccfg),
        .done(done), .cause(cause));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (start === 1'b1) starts++;
        if (cycles == 20000) begin
            num_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // The request is held until ack is seen at an edge; read data is taken at that edge.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        wd  <= d;
        sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Launches a command, checks the busy reading, then polls until ready again.
    task automatic run_cmd(input dsr_cause_t c);
        int n;
        ccfg <= c;
        bus(1'b1, DSR_OFF_CTRL, 32'h1);
        bus(1'b0, DSR_OFF_CTRL, 32'h0);
        `CHK(rd, 32'h1)
        bus(1'b1, DSR_OFF_CTRL, 32'h1);
        bus(1'b0, DSR_OFF_STATUS, 32'h0);
        `CHK(rd[7], 1'b0)
        n = 0;
        do begin
            bus(1'b0, DSR_OFF_STATUS, 32'h0);
            n++;
        end while (rd[7] !== 1'b1 && n < 40);
        `CHK(rd[7], 1'b1)
    endtask

    initial begin
        {cyc, stb, we, fix} = '0;
        adr = 8'h00;
        sel = 4'h0;
        wd = 32'h0;
        drv = '0;
        ccfg = '0;
        rst = 1'b1;
        idle(2);
        rst <= 1'b0;
        bus(1'b0, DSR_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h80)
        bus(1'b0, DSR_OFF_ERROR, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, DSR_OFF_STATUS, 32'hff);
        bus(1'b0, DSR_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h80)
        // Each drive level alone, then all at once.
        for (int i = 0; i < 5; i++) begin
            drv <= dsr_drive_t'(5'h10 >> i);
            idle(2);
            bus(1'b0, DSR_OFF_STATUS, 32'h0);
            `CHK(rd[7:0], 8'h80 | dpos[i])
            `CHK(st_o, 8'h80 | dpos[i])
        end
        drv <= 5'h1f;
        idle(2);
        bus(1'b0, DSR_OFF_STATUS, 32'h0);
        `CHK(rd, 32'hfa)
        drv <= '0;
        fix <= 1'b1;
        @(posedge clk);
        fix <= 1'b0;
        idle(3);
        bus(1'b0, DSR_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h84)
        // One cause at a time, then every cause, then a clean command.
        for (int i = 0; i < 5; i++) begin
            run_cmd(dsr_cause_t'(5'h10 >> i));
            `CHK(rd, 32'h81)
            bus(1'b0, DSR_OFF_ERROR, 32'h0);
            `CHK(rd, {24'h0, cpos[i]})
        end
        run_cmd(5'h1f);
        bus(1'b0, DSR_OFF_ERROR, 32'h0);
        `CHK(rd, 32'hd6)
        run_cmd(5'h00);
        `CHK(rd, 32'h80)
        bus(1'b0, DSR_OFF_ERROR, 32'h0);
        `CHK(rd, 32'h0)
        // Interrupts: raise, mask, unmask, clear.
        bus(1'b1, DSR_OFF_IRQ_ST, 32'h7);
        bus(1'b0, DSR_OFF_IRQ_MK, 32'h0);
        `CHK(rd, 32'h0)
        bus(1'b1, DSR_OFF_IRQ_MK, 32'h3);
        run_cmd(5'h02);
        bus(1'b0, DSR_OFF_IRQ_ST, 32'h0);
        `CHK(rd, 32'h3)
        `CHK(irq, 1'b1)
        bus(1'b1, DSR_OFF_IRQ_MK, 32'h0);
        idle(2);
        `CHK(irq, 1'b0)
        bus(1'b1, DSR_OFF_IRQ_MK, 32'h4);
        drv <= 5'h02;
        idle(3);
        `CHK(irq, 1'b1)
        bus(1'b1, DSR_OFF_IRQ_ST, 32'h7);
        idle(2);
        `CHK(irq, 1'b0)
        bus(1'b0, DSR_OFF_IRQ_ST, 32'h0);
        `CHK(rd, 32'h0)
        // Unmapped place reads zero and ignores writes.
        bus(1'b1, 8'h20, 32'hff);
        bus(1'b0, 8'h20, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(starts, 8)
        tally_and_finish();
    end
endmodule
